// ---- design/cmp_array_top.sv ----
// Counter array with one software timer module behind AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Counter compared with 16-bit compare value
// - Equality sets match flag, may interrupt
// - Match flag cleared only by software
// - Software timer needs both enable bits
// - Low compare byte write clears enable
// - High compare byte write sets enable
// - Idle suspend freezes array during idle
// - Watchdog enable output follows its bit
// - Lock freezes watchdog enable bit
// - Mode bit four reads zero
// - Timebase select picks counter tick source
module cmp_array_top
	import cmp_array_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [31:0] awaddr_i,
	input wire logic awvalid_i,
	output logic awready_o,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] wstrb_i,
	input wire logic wvalid_i,
	output logic wready_o,
	output logic [1:0] bresp_o,
	output logic bvalid_o,
	input wire logic bready_i,
	input wire logic [31:0] araddr_i,
	input wire logic arvalid_i,
	output logic arready_o,
	output logic [31:0] rdata_o,
	output logic [1:0] rresp_o,
	output logic rvalid_o,
	input wire logic rready_i,
	input wire logic cpu_idle_i,
	input wire logic t0_ovf_i,
	input wire logic eci_i,
	input wire logic ext_clk_i,
	output logic irq_o,
	output logic watchdog_enable_o
);
	////////////////////////////////////////////////////////////////////
	// Declarations
	logic [31:0] awaddr_q; // Latched write address
	logic aw_got_q; // Write address held
	logic [7:0] wdata_q; // Latched low data byte
	logic wstrb_q; // Low lane strobe
	logic w_got_q; // Write data held
	logic wr_fire; // Both halves present, do the write
	logic wr_ok; // Write lands on a mapped register
	logic [7:0] wr_idx;
	logic [7:0] rd_val;
	logic [7:0] am_q; // Array mode register
	logic [1:0] mm_q; // Module mode register
	logic [15:0] cmp_q; // Compare value
	logic [1:0] st_q; // Sticky status
	logic [1:0] mask_q; // Interrupt mask
	logic run_q; // Counter run control
	logic [15:0] cnt_q; // Running counter
	logic step_q; // Counter just advanced
	logic tick; // Selected timebase tick
	logic adv; // Counter advances this cycle
	logic ovf_ev;
	logic match_ev;
	logic [1:0] clr; // Write-one-to-clear bits
	logic [1:0] irq_en;
	count_if cnt_bus ();

	// Decode: word aligned, index window only
	function automatic logic hit(input logic [31:0] a);
		logic [7:0] i;
		i = a[9:2];
		hit = (a[31:10] == 22'h0) && (a[1:0] == 2'h0)
			&& (i >= IDX_STATUS) && (i <= IDX_CTRL);
	endfunction : hit

	////////////////////////////////////////////////////////////////////
	// Write channel
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			aw_got_q <= 1'b0;
			awready_o <= 1'b0;
			awaddr_q <= 32'h0;
		end else if (awvalid_i && awready_o) begin
			aw_got_q <= 1'b1;
			awready_o <= 1'b0;
			awaddr_q <= awaddr_i;
		end else if (wr_fire || !aw_got_q) begin
			aw_got_q <= 1'b0;
			awready_o <= 1'b1;
		end
	end

	// Data taken independently of the address
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			w_got_q <= 1'b0;
			wready_o <= 1'b0;
			wdata_q <= 8'h0;
			wstrb_q <= 1'b0;
		end else if (wvalid_i && wready_o) begin
			w_got_q <= 1'b1;
			wready_o <= 1'b0;
			wdata_q <= wdata_i[7:0];
			wstrb_q <= wstrb_i[0];
		end else if (wr_fire || !w_got_q) begin
			w_got_q <= 1'b0;
			wready_o <= 1'b1;
		end
	end

	assign wr_fire = aw_got_q && w_got_q && !bvalid_o;
	assign wr_ok = wr_fire && wstrb_q && hit(awaddr_q);
	assign wr_idx = awaddr_q[9:2];

	// Response held until the master accepts it
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			bvalid_o <= 1'b0;
			bresp_o <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_o <= 1'b1;
			bresp_o <= hit(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
		end else if (bready_i) begin
			bvalid_o <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read channel
	always_comb begin
		unique case (araddr_i[9:2])
			IDX_STATUS: rd_val = {6'h0, st_q};
			IDX_ARRAY_MODE: rd_val = am_q;
			IDX_MOD_MODE: rd_val = {6'h0, mm_q};
			IDX_CMP_LO: rd_val = cmp_q[7:0];
			IDX_CMP_HI: rd_val = cmp_q[15:8];
			IDX_CNT_LO: rd_val = cnt_q[7:0];
			IDX_CNT_HI: rd_val = cnt_q[15:8];
			IDX_MASK: rd_val = {6'h0, mask_q};
			IDX_CTRL: rd_val = {7'h0, run_q};
			default: rd_val = 8'h0;
		endcase
	end

	// Read data sampled at the address handshake
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			arready_o <= 1'b0;
			rvalid_o <= 1'b0;
			rdata_o <= 32'h0;
			rresp_o <= RESP_OKAY;
		end else if (arvalid_i && arready_o) begin
			arready_o <= 1'b0;
			rvalid_o <= 1'b1;
			rdata_o <= hit(araddr_i) ? {24'h0, rd_val} : 32'h0;
			rresp_o <= hit(araddr_i) ? RESP_OKAY : RESP_SLVERR;
		end else if (!rvalid_o || rready_i) begin
			arready_o <= 1'b1;
			rvalid_o <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Array mode register
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			am_q <= ARRAY_MODE_RST;
		end else if (wr_ok && wr_idx == IDX_ARRAY_MODE) begin
			am_q <= wdata_q & ARRAY_MODE_WMASK;
			if (am_q[AM_WATCHDOG_LOCK]) begin
				am_q[AM_WATCHDOG_ENABLE] <= am_q[AM_WATCHDOG_ENABLE];
			end
		end
	end

	// Watchdog enable handed to module two's watchdog logic
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			watchdog_enable_o <= ARRAY_MODE_RST[AM_WATCHDOG_ENABLE];
		end else begin
			watchdog_enable_o <= am_q[AM_WATCHDOG_ENABLE];
		end
	end

	// Module mode; compare byte writes steer the compare enable
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			mm_q <= MM_RST;
		end else if (wr_ok && wr_idx == IDX_MOD_MODE) begin
			mm_q <= wdata_q[1:0];
		end else if (wr_ok && wr_idx == IDX_CMP_LO) begin
			mm_q[MM_CMP_EN] <= 1'b0;
		end else if (wr_ok && wr_idx == IDX_CMP_HI) begin
			mm_q[MM_CMP_EN] <= 1'b1;
		end
	end

	// Compare value; the low-first order keeps matching off mid-load
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			cmp_q <= 16'h0;
		end else if (wr_ok && wr_idx == IDX_CMP_LO) begin
			cmp_q[7:0] <= wdata_q;
		end else if (wr_ok && wr_idx == IDX_CMP_HI) begin
			cmp_q[15:8] <= wdata_q;
		end
	end

	// Mask and run control
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			mask_q <= MASK_RST;
			run_q <= 1'b0;
		end else if (wr_ok && wr_idx == IDX_MASK) begin
			mask_q <= wdata_q[1:0];
		end else if (wr_ok && wr_idx == IDX_CTRL) begin
			run_q <= wdata_q[CTRL_RUN];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Counter
	tick_gen u_tick (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.sel_i(am_q[AM_TB_LSB +: 3]),
		.t0_ovf_i(t0_ovf_i),
		.eci_i(eci_i),
		.ext_clk_i(ext_clk_i),
		.tick_o(tick)
	);

	// Suspended while idle only if asked
	assign adv = tick && run_q && !(am_q[AM_IDLE] && cpu_idle_i);
	assign ovf_ev = adv && (cnt_q == 16'hffff);

	// Plain binary count, natural wrap at all ones
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			cnt_q <= 16'h0;
			step_q <= 1'b0;
		end else begin
			step_q <= adv;
			if (adv) begin
				cnt_q <= cnt_q + 16'h1;
			end
		end
	end
	assign cnt_bus.count = cnt_q;
	assign cnt_bus.step = step_q;

	match_unit u_match (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.cnt(cnt_bus),
		.cmp_val_i(cmp_q),
		.mode_i(mm_q),
		.match_o(match_ev)
	);

	////////////////////////////////////////////////////////////////////
	// Status and interrupt
	assign clr = (wr_ok && wr_idx == IDX_STATUS) ? wdata_q[1:0] : 2'h0;

	// Event wins over a clear in the same cycle; no hardware clear
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			st_q <= 2'h0;
		end else begin
			st_q[ST_MATCH] <= (st_q[ST_MATCH] & ~clr[ST_MATCH])
				| match_ev;
			st_q[ST_OVF] <= (st_q[ST_OVF] & ~clr[ST_OVF]) | ovf_ev;
		end
	end

	// Overflow source needs its own enable as well as the mask
	assign irq_en = {mask_q[ST_OVF] & am_q[AM_OVF_IE], mask_q[ST_MATCH]};

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(st_q & irq_en);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	sequence s_hit;
		step_q && (&mm_q) && (cnt_q == cmp_q);
	endsequence
	sequence s_wrap;
		adv && (cnt_q == 16'hffff);
	endsequence

	property p_match_set;
		s_hit |-> ##2 st_q[ST_MATCH];
	endproperty
	a_match_set: assert property (p_match_set)
		else $error("match flag not set after compare hit");

	property p_match_cause;
		$rose(st_q[ST_MATCH]) |-> $past(&mm_q, 2) && $past(step_q, 2);
	endproperty
	a_match_cause: assert property (p_match_cause)
		else $error("match flag set outside software timer mode");

	property p_match_sticky;
		st_q[ST_MATCH] && !clr[ST_MATCH] |=> st_q[ST_MATCH];
	endproperty
	a_match_sticky: assert property (p_match_sticky)
		else $error("match flag dropped without a clear");

	property p_lo_clear;
		wr_ok && wr_idx == IDX_CMP_LO |=> !mm_q[MM_CMP_EN];
	endproperty
	a_lo_clear: assert property (p_lo_clear)
		else $error("low byte write left compare enabled");

	property p_hi_set;
		wr_ok && wr_idx == IDX_CMP_HI |=> mm_q[MM_CMP_EN];
	endproperty
	a_hi_set: assert property (p_hi_set)
		else $error("high byte write did not enable compare");

	property p_lock;
		am_q[AM_WATCHDOG_LOCK] |=> $stable(am_q[AM_WATCHDOG_ENABLE]);
	endproperty
	a_lock: assert property (p_lock)
		else $error("watchdog enable changed while locked");

	property p_bit4;
		am_q[4] == 1'b0;
	endproperty
	a_bit4: assert property (p_bit4)
		else $error("mode bit four not zero");

	property p_wrap;
		s_wrap |=> (cnt_q == 16'h0) && st_q[ST_OVF] && step_q;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("counter wrap did not set overflow");

	property p_idle;
		run_q && am_q[AM_IDLE] && cpu_idle_i |=> $stable(cnt_q);
	endproperty
	a_idle: assert property (p_idle)
		else $error("counter moved while suspended in idle");

	property p_ovf_irq;
		st_q[ST_OVF] && mask_q[ST_OVF] && am_q[AM_OVF_IE] |=> irq_o;
	endproperty
	a_ovf_irq: assert property (p_ovf_irq)
		else $error("overflow interrupt not raised");
endmodule : cmp_array_top
`default_nettype wire

// ---- design/cmp_array_pkg.sv ----
// Constants shared by the counter array compare block
package cmp_array_pkg;
	// Register indices; byte address on the bus is four times the index
	localparam logic [7:0] IDX_STATUS = 8'hd8;
	localparam logic [7:0] IDX_ARRAY_MODE = 8'hd9;
	localparam logic [7:0] IDX_MOD_MODE = 8'hda;
	localparam logic [7:0] IDX_CMP_LO = 8'hdb;
	localparam logic [7:0] IDX_CMP_HI = 8'hdc;
	localparam logic [7:0] IDX_CNT_LO = 8'hdd;
	localparam logic [7:0] IDX_CNT_HI = 8'hde;
	localparam logic [7:0] IDX_MASK = 8'hdf;
	localparam logic [7:0] IDX_CTRL = 8'he0;
	// Array mode register fields and reset value
	localparam int AM_IDLE = 7;
	localparam int AM_WATCHDOG_ENABLE = 6;
	localparam int AM_WATCHDOG_LOCK = 5;
	localparam int AM_TB_LSB = 1;
	localparam int AM_OVF_IE = 0;
	localparam logic [7:0] ARRAY_MODE_RST = 8'h40;
	localparam logic [7:0] ARRAY_MODE_WMASK = 8'hef;
	// Module mode, status and control fields
	localparam int MM_MATCH_EN = 0;
	localparam int MM_CMP_EN = 1;
	localparam int ST_MATCH = 0;
	localparam int ST_OVF = 1;
	localparam int CTRL_RUN = 0;
	localparam logic [1:0] MM_RST = 2'h0;
	localparam logic [1:0] MASK_RST = 2'h0;
	// Bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Prescaler counts in system clocks or external clock edges
	localparam int DIV_SLOW = 12;
	localparam int DIV_FAST = 4;
	localparam int DIV_EXT = 8;
	// Timebase codes
	typedef enum logic [2:0] {
		TB_SYS_DIV12 = 3'h0,
		TB_SYS_DIV4 = 3'h1,
		TB_T0_OVF = 3'h2,
		TB_ECI_FALL = 3'h3,
		TB_SYS = 3'h4,
		TB_EXT_DIV8 = 3'h5
	} timebase_t;
endpackage : cmp_array_pkg

// ---- design/count_if.sv ----
// Carrier for the running counter value and its step strobe
`timescale 1ns/1ps
`default_nettype none
interface count_if;
	logic [15:0] count; // Counter value
	logic step; // Pulse: counter has just advanced
	modport drv (output count, output step);
	modport mon (input count, input step);
endinterface : count_if
`default_nettype wire

// ---- design/tick_gen.sv ----
// Timebase selection and prescalers for the counter array
`timescale 1ns/1ps
`default_nettype none
module tick_gen
	import cmp_array_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [2:0] sel_i,
	input wire logic t0_ovf_i,
	input wire logic eci_i,
	input wire logic ext_clk_i,
	output logic tick_o
);
	logic [3:0] div_slow_q; // Divide by twelve
	logic [1:0] div_fast_q; // Divide by four
	logic [2:0] div_ext_q; // External edges modulo eight
	logic [1:0] eci_s_q; // Count input synchroniser
	logic eci_old_q; // Previous synchronised level
	logic [1:0] ext_s_q; // External clock synchroniser
	logic ext_old_q;
	logic eci_fall;
	logic ext_rise;
	logic tick_d;

	// Pins pass two flops; idle-high reset avoids a false falling edge
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			eci_s_q <= 2'h3;
			eci_old_q <= 1'b1;
			ext_s_q <= 2'h0;
			ext_old_q <= 1'b0;
		end else begin
			eci_s_q <= {eci_s_q[0], eci_i};
			eci_old_q <= eci_s_q[1];
			ext_s_q <= {ext_s_q[0], ext_clk_i};
			ext_old_q <= ext_s_q[1];
		end
	end
	assign eci_fall = eci_old_q & ~eci_s_q[1];
	assign ext_rise = ~ext_old_q & ext_s_q[1];

	// Free running prescalers
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			div_slow_q <= 4'h0;
			div_fast_q <= 2'h0;
			div_ext_q <= 3'h0;
		end else begin
			div_slow_q <= (div_slow_q == 4'(DIV_SLOW - 1)) ? 4'h0
				: div_slow_q + 4'h1;
			div_fast_q <= div_fast_q + 2'h1;
			if (ext_rise) begin
				div_ext_q <= div_ext_q + 3'h1;
			end
		end
	end

	// Source select; reserved codes give no tick
	always_comb begin
		unique case (sel_i)
			TB_SYS_DIV12: tick_d = (div_slow_q == 4'(DIV_SLOW - 1));
			TB_SYS_DIV4: tick_d = (div_fast_q == 2'(DIV_FAST - 1));
			TB_T0_OVF: tick_d = t0_ovf_i;
			TB_ECI_FALL: tick_d = eci_fall;
			TB_SYS: tick_d = 1'b1;
			TB_EXT_DIV8: tick_d = ext_rise
				&& (div_ext_q == 3'(DIV_EXT - 1));
			default: tick_d = 1'b0;
		endcase
	end

	// Registered tick, one cycle wide except under TB_SYS, which holds it high
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			tick_o <= 1'b0;
		end else begin
			tick_o <= tick_d;
		end
	end
endmodule : tick_gen
`default_nettype wire

// ---- design/match_unit.sv ----
// Compare unit of one capture/compare module in software timer mode
`timescale 1ns/1ps
`default_nettype none
module match_unit
	import cmp_array_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	count_if.mon cnt,
	input wire logic [15:0] cmp_val_i,
	input wire logic [1:0] mode_i,
	output logic match_o
);
	logic sw_timer; // Both enables set

	assign sw_timer = mode_i[MM_CMP_EN] & mode_i[MM_MATCH_EN];

	// Only a fresh counter value can match, so a static equal value
	// does not fire again every cycle
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			match_o <= 1'b0;
		end else begin
			match_o <= cnt.step && sw_timer
				&& (cnt.count == cmp_val_i);
		end
	end
endmodule : match_unit
`default_nettype wire

// ---- bench/cmp_array_top_tb.sv ----
// Self-checking bench for the counter array compare block
`timescale 1ns/1ps
`default_nettype none
module cmp_array_top_tb;
	import cmp_array_pkg::*;
	// One expected read: response, compared bits, data
	typedef struct packed {logic [1:0] r; logic [7:0] m; logic [7:0] d;} rnote_t;
	logic ref_clk, rst, awvalid, wvalid, bready, arvalid, rready;
	logic [31:0] awaddr, wdata, araddr;
	logic [3:0] wstrb;
	logic cpu_idle, ext_clk;
	logic t0_ovf = 1'b0, external_count_input = 1'b0; // Driven by the pulse process only
	logic awready, wready, bvalid, arready, rvalid, irq, wd_en;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [15:0] cyc = 16'h0; // Free cycle count
	logic [15:0] c, n1, n2; // Compare picks
	logic [7:0] rv; // Last read byte
	int n_mismatch, n_checks;
	int unsigned seed_v;
	rnote_t rq[$]; // Expected reads
	logic [1:0] bq[$]; // Expected write answers
	int lo_t[8] = '{18, 58, 22, 13, 238, 8, 0, 0}; // Step count window
	int hi_t[8] = '{23, 63, 27, 17, 247, 13, 0, 0};

	cmp_array_top u_dut (.ref_clk_i(ref_clk), .rst_i(rst),
		.awaddr_i(awaddr), .awvalid_i(awvalid), .awready_o(awready),
		.wdata_i(wdata), .wstrb_i(wstrb), .wvalid_i(wvalid),
		.wready_o(wready), .bresp_o(bresp), .bvalid_o(bvalid),
		.bready_i(bready), .araddr_i(araddr), .arvalid_i(arvalid),
		.arready_o(arready), .rdata_o(rdata), .rresp_o(rresp),
		.rvalid_o(rvalid), .rready_i(rready), .cpu_idle_i(cpu_idle),
		.t0_ovf_i(t0_ovf), .eci_i(external_count_input), .ext_clk_i(ext_clk),
		.irq_o(irq), .watchdog_enable_o(wd_en));

	////////////////////////////////////////////////////////////////////
	// System clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// External clock with an unrelated period so phases drift
	initial begin
		ext_clk = 1'b0;
		forever #13.7 ext_clk = ~ext_clk;
	end
	// Timer-0 pulse every 10 cycles, count pin falls every 16
	always @(posedge ref_clk) begin
		cyc <= cyc + 16'h1;
		t0_ovf <= (cyc % 10 == 9);
		external_count_input <= cyc[3];
	end

	////////////////////////////////////////////////////////////////////
	task automatic fail(input string s);
		n_mismatch++;
		$display("[ERR] %0t %s", $time, s);
	endtask : fail
	task automatic cmp_rd(input logic [31:0] d, input logic [1:0] r,
		input rnote_t e);
		n_checks++;
		if ((d[7:0] & e.m) !== (e.d & e.m) || d[31:8] !== 24'h0 || r !== e.r)
			fail("read data or response differs");
	endtask : cmp_rd
	task automatic cmp_wr(input logic [1:0] r, input logic [1:0] e);
		n_checks++;
		if (r !== e)
			fail("write response differs");
	endtask : cmp_wr
	task automatic chk(input logic a, input logic e);
		n_checks++;
		if (a !== e)
			fail("output level differs");
	endtask : chk
	task automatic cmp_val(input logic [7:0] a, input int lo, input int hi);
		n_checks++;
		if (^a === 1'bx || a < lo || a > hi)
			fail("counter advance out of range");
	endtask : cmp_val

	// Scoreboard: takes the oldest note whenever an answer is handed over
	always @(posedge ref_clk) begin
		if (rvalid === 1'b1 && rready) begin
			if (rq.size() == 0)
				fail("unexpected read answer");
			else
				cmp_rd(rdata, rresp, rq.pop_front());
		end
		if (bvalid === 1'b1 && bready) begin
			if (bq.size() == 0)
				fail("unexpected write answer");
			else
				cmp_wr(bresp, bq.pop_front());
		end
	end

	////////////////////////////////////////////////////////////////////
	// Bus write; address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] idx, input logic [7:0] d,
		input logic [1:0] e = RESP_OKAY);
		bit a;
		bit w;
		int n;
		a = 0;
		w = 0;
		n = 0;
		bq.push_back(e);
		awaddr <= {22'h0, idx, 2'h0};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
			if (!a && awready === 1'b1) begin
				a = 1;
				awvalid <= 1'b0;
			end
			if (!w && wready === 1'b1) begin
				w = 1;
				wvalid <= 1'b0;
			end
		end while (bvalid !== 1'b1 && n < 200);
		bready <= 1'b0;
		if (n >= 200)
			fail("write never answered");
	endtask : wr
	// Bus read; rv keeps the byte for stimulus choices and the span advance check
	task automatic rd(input logic [7:0] idx, input logic [7:0] e,
		input logic [7:0] m, input logic [1:0] er = RESP_OKAY);
		rnote_t nt;
		int n;
		n = 0;
		nt = '{er, m, e};
		rq.push_back(nt);
		araddr <= {22'h0, idx, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
			if (arready === 1'b1)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 200);
		rv = rdata[7:0];
		rready <= 1'b0;
		if (n >= 200)
			fail("read never answered");
	endtask : rd
	// Run the counter 240 cycles under one mode and bound its advance
	task automatic span(input logic [7:0] am, input int lo, input int hi);
		logic [7:0] v0;
		wr(IDX_ARRAY_MODE, am);
		rd(IDX_CNT_LO, 8'h0, 8'h0);
		v0 = rv;
		wr(IDX_CTRL, 8'h01);
		repeat (240) @(posedge ref_clk);
		wr(IDX_CTRL, 8'h00);
		rd(IDX_CNT_LO, 8'h0, 8'h0);
		cmp_val(rv - v0, lo, hi);
	endtask : span

	// Verdict and end of run
	task automatic final_report;
		if (n_mismatch == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report

	// Watchdog: the whole sequence needs about 70000 cycles
	initial begin
		repeat (90000) @(posedge ref_clk);
		n_mismatch++;
		final_report();
	end

	////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready, cpu_idle} = 6'h0;
		{awaddr, wdata, araddr} = 96'h0;
		wstrb = 4'h1; // Only the low lane carries a register
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		seed_v = $urandom(98950);
		// Reset values and the unused mode bit
		rd(IDX_ARRAY_MODE, 8'h40, 8'hff);
		chk(wd_en, 1'b1);
		rd(IDX_STATUS, 8'h00, 8'hff);
		wr(IDX_ARRAY_MODE, 8'h10);
		rd(IDX_ARRAY_MODE, 8'h00, 8'hff);
		chk(wd_en, 1'b0);
		// Lock value before each write decides the enable bit
		wr(IDX_ARRAY_MODE, 8'h60);
		rd(IDX_ARRAY_MODE, 8'h60, 8'hff);
		wr(IDX_ARRAY_MODE, 8'h20);
		rd(IDX_ARRAY_MODE, 8'h60, 8'hff);
		wr(IDX_ARRAY_MODE, 8'h00);
		rd(IDX_ARRAY_MODE, 8'h40, 8'hff);
		chk(wd_en, 1'b1);
		wr(IDX_ARRAY_MODE, 8'h00);
		rd(IDX_ARRAY_MODE, 8'h00, 8'hff);
		// Unmapped place and read-only counter
		wr(8'he1, 8'h55, RESP_SLVERR);
		rd(8'he1, 8'h00, 8'hff, RESP_SLVERR);
		wr(IDX_CNT_HI, 8'h12);
		rd(IDX_CNT_HI, 8'h00, 8'hff);
		// Every timebase code, reserved ones give no ticks
		for (int k = 0; k < 8; k++)
			span({4'h0, k[2:0], 1'b0}, lo_t[k], hi_t[k]);
		// Idle freezes the array only when suspension is asked for
		cpu_idle <= 1'b1;
		span(8'h88, 0, 0);
		span(8'h08, 238, 247);
		cpu_idle <= 1'b0;
		// Compare without match enable must stay silent
		rd(IDX_CNT_LO, 8'h0, 8'h0);
		c[7:0] = rv;
		rd(IDX_CNT_HI, 8'h0, 8'h0);
		c[15:8] = rv;
		n1 = c + 16'd30 + 16'($urandom % 16);
		wr(IDX_CMP_LO, n1[7:0]);
		wr(IDX_CMP_HI, n1[15:8]);
		wr(IDX_MOD_MODE, 8'h02);
		wr(IDX_MASK, 8'h01);
		wr(IDX_CTRL, 8'h01);
		repeat (120) @(posedge ref_clk);
		wr(IDX_CTRL, 8'h00);
		rd(IDX_STATUS, 8'h00, 8'h01);
		chk(irq, 1'b0);
		// Low byte first clears the enable, high byte sets it
		n2 = c + 16'd200 + 16'($urandom % 32);
		wr(IDX_CMP_LO, n2[7:0]);
		rd(IDX_MOD_MODE, 8'h00, 8'hff);
		wr(IDX_MOD_MODE, 8'h01);
		wr(IDX_CMP_HI, n2[15:8]);
		rd(IDX_MOD_MODE, 8'h03, 8'hff);
		// Match raises the flag and the interrupt; reads do not clear
		wr(IDX_CTRL, 8'h01);
		for (int k = 0; k < 400 && irq !== 1'b1; k++)
			@(posedge ref_clk);
		chk(irq, 1'b1);
		wr(IDX_CTRL, 8'h00);
		rd(IDX_STATUS, 8'h01, 8'h01);
		rd(IDX_STATUS, 8'h01, 8'h01);
		chk(irq, 1'b1);
		wr(IDX_STATUS, 8'h01);
		rd(IDX_STATUS, 8'h00, 8'h01);
		repeat (3) @(posedge ref_clk);
		chk(irq, 1'b0);
		// Full wrap sets overflow; its interrupt waits for the enable
		wr(IDX_MASK, 8'h02);
		wr(IDX_ARRAY_MODE, 8'h08);
		wr(IDX_CTRL, 8'h01);
		repeat (65600) @(posedge ref_clk);
		wr(IDX_CTRL, 8'h00);
		rd(IDX_STATUS, 8'h02, 8'h02);
		chk(irq, 1'b0);
		wr(IDX_ARRAY_MODE, 8'h09);
		repeat (3) @(posedge ref_clk);
		chk(irq, 1'b1);
		wr(IDX_STATUS, 8'h03);
		repeat (3) @(posedge ref_clk);
		chk(irq, 1'b0);
		repeat (4) @(posedge ref_clk);
		final_report();
	end
endmodule : cmp_array_top_tb
`default_nettype wire
